// *** core/perh_pkg.sv ***
// Shared constants for the power event, reset button and thermal trip block.
// Assumes a 100 MHz device clock in the always-on well.
package perh_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DEBOUNCE_MS = 16;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ * 1000 / 1000;
	localparam int unsigned HOLD_MIN_MS = 5;
	localparam int unsigned HOLD_MIN_CYC = HOLD_MIN_MS * 1000 * CLK_MHZ;
	localparam int unsigned TRIP_LATENCY_US = 1;
	localparam int unsigned TRIP_LATENCY_CYC = TRIP_LATENCY_US * CLK_MHZ;
	localparam int unsigned GLITCH_NS = 25;
	localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] ROUTE_SMI = 2'h0;
	localparam logic [1:0] ROUTE_SCI = 2'h1;
	localparam logic [1:0] ROUTE_WAKE = 2'h2;
	localparam logic [1:0] ROUTE_NONE = 2'h3;
	localparam logic SYNC_RESET_VAL = 1'h1;
endpackage

// *** core/perh_sync.sv ***
// Two-flop synchroniser bank for the asynchronous inputs of the block.
// Assumes inputs change without relation to clk; reset value is all ones (idle high).
`timescale 1ns/1ns
`default_nettype none
module perh_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import perh_pkg::*;
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} perh_sync_state_t;
	perh_sync_state_t st_ff;
	perh_sync_state_t nxt_st;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta = async_in;
		nxt_st.stable = st_ff.meta;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '{meta: {WIDTH{SYNC_RESET_VAL}}, stable: {WIDTH{SYNC_RESET_VAL}}};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign sync_out = st_ff.stable;
endmodule
`default_nettype wire

// *** core/perh_top.sv ***
// Power event routing, reset button handling, thermal trip shutdown and resume holdoff.
// Assumes a free-running 100 MHz clk, synchronous active-high reset, async pins.
// Contract
// - Event only on a falling edge of the external event input.
// - Detected event goes to SMI, SCI or optionally wake.
// - Internal bus 0 event sets its own status with same routing.
// - Button recognised on falling edge, or after 16 ms with debounce.
// - Button reset held asserted for 5 to 6 ms regardless of button.
// - Rearm only after button inactive and full S0 with platform reset released.
// - Button reset is host partition reset; power cycle when control bit set.
// - Button acts only while core power good is high.
// - Thermal trip goes straight to S5, sleep outputs low, status set.
// - Sleep outputs low within 1 us of trip sampled active.
// - Trip low pulses shorter than 25 ns are ignored.
// - Trip monitored from platform reset release, or processor power good; code needs processor power good plus reset release or trip valid point.
// - Monitoring stops when processor power good deasserts.
// - Thermal trip clears power button status.
// - Resume delayed after aux sleep release while holdoff asserted.
// - Holdoff ignored outside Sx entry with aux sleep asserted.
// - Holdoff pin is general input until firmware enables the function.
// - No flash access while aux sleep asserted or holdoff still holding.
`timescale 1ns/1ns
`default_nettype none
module perh_top #(
	parameter int unsigned DEBOUNCE_CYCLES = perh_pkg::DEBOUNCE_CYC,
	parameter int unsigned HOLD_CYCLES = perh_pkg::HOLD_MIN_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pm_event_n,
	input wire logic internal_bus0_pm_event,
	input wire logic [1:0] pm_event_route,
	input wire logic internal_bus0_status_clear,
	input wire logic pm_event_status_clear,
	input wire logic reset_button_n,
	input wire logic debounce_enable,
	input wire logic power_cycle_select,
	input wire logic core_power_good,
	input wire logic platform_reset_n,
	input wire logic in_full_s0,
	input wire logic thermal_trip_n,
	input wire logic trip_valid_point,
	input wire logic processor_power_good,
	input wire logic thermal_trip_status_clear,
	input wire logic power_button_event,
	input wire logic power_button_status_clear,
	input wire logic sleep_s3_req_n,
	input wire logic sleep_s4_req_n,
	input wire logic sleep_s5_req_n,
	input wire logic aux_sleep_out_n,
	input wire logic in_sx_entry,
	input wire logic resume_holdoff_n,
	input wire logic holdoff_function_enable,
	input wire logic suspend_reset_n,
	output logic pm_event_status,
	output logic internal_bus0_pm_event_status,
	output logic smi_pulse,
	output logic sci_pulse,
	output logic wake_pulse,
	output logic host_reset_active,
	output logic power_cycle_active,
	output logic sleep_s3_out_n,
	output logic sleep_s4_out_n,
	output logic sleep_s5_out_n,
	output logic thermal_trip_status,
	output logic power_button_status,
	output logic resume_allowed,
	output logic flash_access_allowed,
	output logic holdoff_gpio_level
);
	import perh_pkg::*;

	logic [3:0] sync_raw;
	logic [3:0] sync_q;
	logic pme_s;
	logic btn_s;
	logic trip_s;
	logic hold_s;

	assign sync_raw = {resume_holdoff_n, thermal_trip_n, reset_button_n, pm_event_n};
	// The four asynchronous pins (event, button, trip, holdoff) pass through two flops first.
	perh_sync #(.WIDTH(4)) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in(sync_raw),
		.sync_out(sync_q)
	);
	assign pme_s = sync_q[0];
	assign btn_s = sync_q[1];
	assign trip_s = sync_q[2];
	assign hold_s = sync_q[3];

	typedef enum logic [1:0] {
		BTN_IDLE = 2'h0,
		BTN_DEBOUNCE = 2'h1,
		BTN_HOLD = 2'h2,
		BTN_REARM = 2'h3
	} perh_btn_t;

	typedef struct packed {
		logic pme_prev;
		logic pme_sts;
		logic b0_sts;
		logic smi;
		logic sci;
		logic wake;
		perh_btn_t btn;
		logic [31:0] cnt;
		logic btn_prev;
		logic host_rst;
		logic pwr_cyc;
		logic [3:0] glitch_cnt;
		logic tripped;
		logic trip_sts;
		logic pb_sts;
		logic s3_n;
		logic s4_n;
		logic s5_n;
		logic holding;
		logic resume_ok;
		logic flash_ok;
		logic gpio_lvl;
	} perh_state_t;

	perh_state_t st_ff;
	perh_state_t nxt_st;
	logic pme_fall;
	logic new_evt;
	logic trip_monitor;
	logic holdoff_active;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.smi = 1'h0;
		nxt_st.sci = 1'h0;
		nxt_st.wake = 1'h0;
		nxt_st.pme_prev = pme_s;
		nxt_st.btn_prev = btn_s;
		// Only a high to low transition counts.
		pme_fall = st_ff.pme_prev & ~pme_s;
		new_evt = pme_fall | internal_bus0_pm_event;
		// Set wins over a clear in the same cycle.
		nxt_st.b0_sts = internal_bus0_pm_event | (st_ff.b0_sts & ~internal_bus0_status_clear);
		nxt_st.pme_sts = pme_fall | (st_ff.pme_sts & ~pm_event_status_clear);
		if (new_evt) begin
			// Both event sources share one routing choice.
			unique case (pm_event_route)
				ROUTE_SMI: nxt_st.smi = 1'h1;
				ROUTE_SCI: nxt_st.sci = 1'h1;
				ROUTE_WAKE: nxt_st.wake = 1'h1;
				ROUTE_NONE: nxt_st.wake = 1'h0;
			endcase
		end

		// Button sequencer; counter reused for debounce and hold time.
		unique case (st_ff.btn)
			BTN_IDLE: begin
				nxt_st.cnt = 32'h0;
				// Falling edge with core power good only.
				if (core_power_good && st_ff.btn_prev && !btn_s) begin
					if (debounce_enable) begin
						nxt_st.btn = BTN_DEBOUNCE;
					end else begin
						nxt_st.btn = BTN_HOLD;
						nxt_st.host_rst = 1'h1;
						nxt_st.pwr_cyc = power_cycle_select;
					end
				end
			end
			BTN_DEBOUNCE: begin
				if (btn_s || !core_power_good) begin
					nxt_st.btn = BTN_IDLE;
				end else if (st_ff.cnt >= DEBOUNCE_CYCLES - 1) begin
					// Button held low for the whole debounce time.
					nxt_st.btn = BTN_HOLD;
					nxt_st.cnt = 32'h0;
					nxt_st.host_rst = 1'h1;
					nxt_st.pwr_cyc = power_cycle_select;
				end else begin
					nxt_st.cnt = st_ff.cnt + 32'h1;
				end
			end
			BTN_HOLD: begin
				// Held for the minimum time whatever the button does.
				if (st_ff.cnt >= HOLD_CYCLES - 1) begin
					nxt_st.btn = BTN_REARM;
					nxt_st.cnt = 32'h0;
					nxt_st.host_rst = 1'h0;
					nxt_st.pwr_cyc = 1'h0;
				end else begin
					nxt_st.cnt = st_ff.cnt + 32'h1;
				end
			end
			BTN_REARM: begin
				// Needs a debounced release and a full S0 with reset gone.
				if (!btn_s) begin
					nxt_st.cnt = 32'h0;
				end else if (st_ff.cnt < DEBOUNCE_CYCLES) begin
					nxt_st.cnt = st_ff.cnt + 32'h1;
				end
				if (st_ff.cnt >= DEBOUNCE_CYCLES && in_full_s0 && platform_reset_n) begin
					nxt_st.btn = BTN_IDLE;
					nxt_st.cnt = 32'h0;
				end
			end
		endcase

		// Monitoring window for the trip input.
		trip_monitor = processor_power_good && (trip_valid_point || platform_reset_n);
		// Low pulses must last the glitch time before they count.
		if (!trip_monitor || trip_s) begin
			nxt_st.glitch_cnt = 4'h0;
		end else if (st_ff.glitch_cnt < 4'(GLITCH_CYC)) begin
			nxt_st.glitch_cnt = st_ff.glitch_cnt + 4'h1;
		end
		if (trip_monitor && !trip_s && st_ff.glitch_cnt >= 4'(GLITCH_CYC) - 4'h1) begin
			nxt_st.tripped = 1'h1;
		end else if (reset) begin
			nxt_st.tripped = 1'h0;
		end
		nxt_st.trip_sts = nxt_st.tripped & ~st_ff.tripped
			| (st_ff.trip_sts & ~thermal_trip_status_clear);
		if (nxt_st.tripped && !st_ff.tripped) begin
			nxt_st.pb_sts = 1'h0;
		end else begin
			nxt_st.pb_sts = power_button_event | (st_ff.pb_sts & ~power_button_status_clear);
		end
		// Trip bypasses the normal sequence and forces all three low at once.
		nxt_st.s3_n = sleep_s3_req_n & ~nxt_st.tripped;
		nxt_st.s4_n = sleep_s4_req_n & ~nxt_st.tripped;
		nxt_st.s5_n = sleep_s5_req_n & ~nxt_st.tripped;

		// Function only after firmware enables it; else pin is a plain input.
		nxt_st.gpio_lvl = hold_s;
		// Latched only during Sx entry with aux sleep asserted.
		holdoff_active = holdoff_function_enable && suspend_reset_n && !hold_s;
		if (!holdoff_function_enable || !suspend_reset_n || hold_s) begin
			nxt_st.holding = 1'h0;
		end else if (in_sx_entry && !aux_sleep_out_n) begin
			nxt_st.holding = 1'h1;
		end
		// Resume waits out the holdoff after aux sleep releases.
		nxt_st.resume_ok = aux_sleep_out_n & ~(nxt_st.holding & holdoff_active);
		// Flash stays off while aux sleep or holdoff holds.
		nxt_st.flash_ok = suspend_reset_n & aux_sleep_out_n & ~(nxt_st.holding & holdoff_active);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '{pme_prev: 1'h1, btn_prev: 1'h1, btn: BTN_IDLE, s3_n: 1'h1,
				s4_n: 1'h1, s5_n: 1'h1, gpio_lvl: 1'h1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pm_event_status = st_ff.pme_sts;
	assign internal_bus0_pm_event_status = st_ff.b0_sts;
	assign smi_pulse = st_ff.smi;
	assign sci_pulse = st_ff.sci;
	assign wake_pulse = st_ff.wake;
	assign host_reset_active = st_ff.host_rst;
	assign power_cycle_active = st_ff.pwr_cyc;
	assign sleep_s3_out_n = st_ff.s3_n;
	assign sleep_s4_out_n = st_ff.s4_n;
	assign sleep_s5_out_n = st_ff.s5_n;
	assign thermal_trip_status = st_ff.trip_sts;
	assign power_button_status = st_ff.pb_sts;
	assign resume_allowed = st_ff.resume_ok;
	assign flash_access_allowed = st_ff.flash_ok;
	assign holdoff_gpio_level = st_ff.gpio_lvl;

	// A falling edge of the synced event input raises status next edge.
	a_pme_fall_sets: assert property (@(posedge clk) disable iff (reset)
		(st_ff.pme_prev && !pme_s) |=> pm_event_status)
		else $error("event edge did not set status");
	// A rising edge never causes an event on its own.
	a_pme_rise_quiet: assert property (@(posedge clk) disable iff (reset)
		(!st_ff.pme_prev && pme_s && !internal_bus0_pm_event)
		|=> !(smi_pulse || sci_pulse || wake_pulse))
		else $error("rising edge produced an event");
	a_route_smi: assert property (@(posedge clk) disable iff (reset)
		(new_evt && pm_event_route == ROUTE_SMI) |=> smi_pulse && !sci_pulse)
		else $error("event not routed to smi");
	a_b0_status: assert property (@(posedge clk) disable iff (reset)
		internal_bus0_pm_event |=> internal_bus0_pm_event_status)
		else $error("bus 0 status not set");
	sequence s_btn_start;
		st_ff.btn == BTN_IDLE && core_power_good && st_ff.btn_prev && !btn_s && !debounce_enable;
	endsequence
	a_btn_no_debounce: assert property (@(posedge clk) disable iff (reset)
		s_btn_start |=> host_reset_active)
		else $error("button edge not recognised");
	a_btn_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(host_reset_active) |-> host_reset_active [*8])
		else $error("button reset released early");
	a_btn_pgood: assert property (@(posedge clk) disable iff (reset)
		(st_ff.btn == BTN_IDLE && !core_power_good) |=> !$rose(host_reset_active))
		else $error("button acted without power good");
	a_rearm_s0: assert property (@(posedge clk) disable iff (reset)
		(st_ff.btn == BTN_REARM && !platform_reset_n) |=> st_ff.btn != BTN_IDLE)
		else $error("rearmed while platform in reset");
	a_pwr_cycle: assert property (@(posedge clk) disable iff (reset)
		(s_btn_start and power_cycle_select) |=> power_cycle_active)
		else $error("power cycle select ignored");
	a_trip_shutdown: assert property (@(posedge clk) disable iff (reset)
		(trip_monitor && !trip_s) [*3] |-> ##[1:2] (!sleep_s3_out_n && !sleep_s4_out_n
		&& !sleep_s5_out_n && thermal_trip_status))
		else $error("trip did not drive sleep outputs low");
	a_trip_glitch: assert property (@(posedge clk) disable iff (reset)
		(!st_ff.tripped && trip_s) ##1 !trip_s ##1 trip_s |=> !st_ff.tripped)
		else $error("short trip glitch caused shutdown");
	a_trip_unmon: assert property (@(posedge clk) disable iff (reset)
		(!processor_power_good && !st_ff.tripped) |=> !st_ff.tripped)
		else $error("trip honoured without processor power good");
	a_trip_pb_clear: assert property (@(posedge clk) disable iff (reset)
		$rose(st_ff.tripped) |-> !power_button_status)
		else $error("trip did not clear power button status");
	a_flash_block: assert property (@(posedge clk) disable iff (reset)
		!aux_sleep_out_n |=> !flash_access_allowed)
		else $error("flash allowed during aux sleep");
	a_holdoff_ignored: assert property (@(posedge clk) disable iff (reset)
		(!holdoff_function_enable && aux_sleep_out_n) |=> resume_allowed)
		else $error("holdoff acted while not enabled");
endmodule
`default_nettype wire

// *** test/perh_ec_model.sv ***
// Embedded controller model: owns suspend reset and the resume holdoff pin.
// Assumes the bench clock and reset; chip-select low counts as flash activity.
`timescale 1ns/1ns
`default_nettype none
module perh_ec_model #(
	parameter int WINDOW_CYC = 30,
	parameter int WORK_CYC = 12
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic aux_sleep_out_n,
	input wire logic in_full_s0,
	input wire logic flash_chip_select0_n,
	output logic suspend_reset_n,
	output logic resume_holdoff_n
);
	int cnt = 0;
	logic booted = 1'h0;
	logic busy = 1'h0;
	// The window is much shorter than the real one; only its order matters here.
	always @(posedge clk) begin
		if (reset) begin
			cnt <= 0;
			booted <= 1'h0;
			busy <= 1'h0;
			resume_holdoff_n <= 1'h1;
			suspend_reset_n <= 1'h0;
		end else if (!suspend_reset_n) begin
			cnt <= cnt + 1;
			if (cnt == WORK_CYC) suspend_reset_n <= 1'h1;
		end else if (!busy) begin
			cnt <= 0;
			if (in_full_s0) booted <= 1'h1;
			if (booted && !aux_sleep_out_n) begin
				busy <= 1'h1;
				resume_holdoff_n <= 1'h0;
			end
		end else begin
			cnt <= cnt + 1;
			if (cnt < WINDOW_CYC && !flash_chip_select0_n) begin
				busy <= 1'h0;
				booted <= 1'h0;
				resume_holdoff_n <= 1'h1;
			end else if (cnt == WINDOW_CYC + WORK_CYC) begin
				busy <= 1'h0;
				resume_holdoff_n <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the power event, button reset, trip and holdoff block.
// Assumes the controller model drives suspend reset and the holdoff pin.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import perh_pkg::*;
	localparam int DEB = 20;
	localparam int HOLD = 10;
	localparam int LIMIT = 5000;
	logic clk = 1'h0, reset = 1'h1, pm_event_n = 1'h1, internal_bus0_pm_event = 1'h0;
	logic [1:0] pm_event_route = 2'h0;
	logic internal_bus0_status_clear = 1'h0, pm_event_status_clear = 1'h0;
	logic reset_button_n = 1'h1, debounce_enable = 1'h0, power_cycle_select = 1'h0;
	logic core_power_good = 1'h1, platform_reset_n = 1'h1, in_full_s0 = 1'h1;
	logic thermal_trip_n = 1'h1, trip_valid_point = 1'h0, processor_power_good = 1'h1;
	logic thermal_trip_status_clear = 1'h0, power_button_event = 1'h0;
	logic power_button_status_clear = 1'h0, sleep_s3_req_n = 1'h1, sleep_s4_req_n = 1'h1;
	logic sleep_s5_req_n = 1'h1, aux_sleep_out_n = 1'h1, in_sx_entry = 1'h0;
	logic holdoff_function_enable = 1'h0, cs_n = 1'h1;
	logic resume_holdoff_n, suspend_reset_n, pm_event_status, internal_bus0_pm_event_status;
	logic smi_pulse, sci_pulse, wake_pulse, host_reset_active, power_cycle_active;
	logic sleep_s3_out_n, sleep_s4_out_n, sleep_s5_out_n, thermal_trip_status;
	logic power_button_status, resume_allowed, flash_access_allowed, holdoff_gpio_level;
	logic [2:0] exp_q[$];
	int mismatches = 0, comparisons = 0, cycles = 0, n;
	perh_top #(.DEBOUNCE_CYCLES(DEB), .HOLD_CYCLES(HOLD)) u_dut (.clk, .reset, .pm_event_n,
		.internal_bus0_pm_event, .pm_event_route, .internal_bus0_status_clear,
		.pm_event_status_clear, .reset_button_n, .debounce_enable, .power_cycle_select,
		.core_power_good, .platform_reset_n, .in_full_s0, .thermal_trip_n, .trip_valid_point,
		.processor_power_good, .thermal_trip_status_clear, .power_button_event,
		.power_button_status_clear, .sleep_s3_req_n, .sleep_s4_req_n, .sleep_s5_req_n,
		.aux_sleep_out_n, .in_sx_entry, .resume_holdoff_n, .holdoff_function_enable,
		.suspend_reset_n, .pm_event_status, .internal_bus0_pm_event_status, .smi_pulse,
		.sci_pulse, .wake_pulse, .host_reset_active, .power_cycle_active, .sleep_s3_out_n,
		.sleep_s4_out_n, .sleep_s5_out_n, .thermal_trip_status, .power_button_status,
		.resume_allowed, .flash_access_allowed, .holdoff_gpio_level);
	perh_ec_model u_ec (.clk, .reset, .aux_sleep_out_n, .in_full_s0,
		.flash_chip_select0_n(cs_n), .suspend_reset_n, .resume_holdoff_n);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wait_for(ref logic s, input logic v, input int k);
		n = 0;
		while (s !== v && n < k) begin
			@(negedge clk);
			n++;
		end
		// Hand back on a rising edge so the next drive lands where all others do.
		@(posedge clk);
	endtask
	// Route pulses are only taken off the queue when one shows, so a stray one is caught too.
	always @(negedge clk) begin
		if (!reset && (smi_pulse || sci_pulse || wake_pulse)) begin
			if (exp_q.size() == 0) check({smi_pulse, sci_pulse, wake_pulse}, 3'h0);
			else check({smi_pulse, sci_pulse, wake_pulse}, exp_q.pop_front());
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		n = $urandom(17410);
		tick(10);
		reset <= 1'h0;
		tick(20);
		for (int i = 0; i < 4; i++) begin
			pm_event_route <= 2'(i);
			tick(1);
			pm_event_n <= 1'h0;
			if (i < 3) exp_q.push_back(3'h4 >> i);
			tick(6);
			pm_event_n <= 1'h1;
			tick(2 + $urandom % 4);
		end
		check(pm_event_status, 1'h1);
		pm_event_route <= 2'h1;
		internal_bus0_pm_event <= 1'h1;
		exp_q.push_back(3'h2);
		tick(1);
		internal_bus0_pm_event <= 1'h0;
		tick(6);
		check(internal_bus0_pm_event_status, 1'h1);
		{pm_event_status_clear, internal_bus0_status_clear} <= 2'h3;
		tick(1);
		{pm_event_status_clear, internal_bus0_status_clear} <= 2'h0;
		tick(3);
		check({pm_event_status, internal_bus0_pm_event_status}, 2'h0);
		$display("event routing test done");
		power_cycle_select <= 1'h1;
		reset_button_n <= 1'h0;
		wait_for(host_reset_active, 1'h1, 20);
		check(power_cycle_active, 1'h1);
		wait_for(host_reset_active, 1'h0, 100);
		check(n, HOLD);
		tick(5);
		check(host_reset_active, 1'h0);
		reset_button_n <= 1'h1;
		power_cycle_select <= 1'h0;
		debounce_enable <= 1'h1;
		tick(DEB + 10);
		reset_button_n <= 1'h0;
		wait_for(host_reset_active, 1'h1, DEB + 20);
		check(n >= DEB && n < DEB + 8, 1'h1);
		check(power_cycle_active, 1'h0);
		tick(HOLD + 2);
		reset_button_n <= 1'h1;
		tick(DEB + 10);
		for (int j = 0; j < 2; j++) begin
			{core_power_good, in_full_s0, platform_reset_n} <= j ? 3'h4 : 3'h3;
			// Second pass leaves the sequencer waiting to rearm before pressing again.
			if (j) begin
				reset_button_n <= 1'h0;
				wait_for(host_reset_active, 1'h1, DEB + 20);
				check(host_reset_active, 1'h1);
				tick(HOLD + 2);
				reset_button_n <= 1'h1;
				tick(DEB + 10);
			end
			reset_button_n <= 1'h0;
			wait_for(host_reset_active, 1'h1, DEB + 20);
			check(host_reset_active, 1'h0);
			reset_button_n <= 1'h1;
			{core_power_good, in_full_s0, platform_reset_n} <= 3'h7;
			tick(DEB + 10);
		end
		$display("button reset test done");
		{holdoff_function_enable, in_sx_entry, aux_sleep_out_n} <= 3'h6;
		tick(8);
		check(flash_access_allowed, 1'h0);
		aux_sleep_out_n <= 1'h1;
		tick(4);
		check({resume_allowed, flash_access_allowed}, 2'h0);
		wait_for(resume_allowed, 1'h1, 80);
		check({resume_allowed, flash_access_allowed}, 2'h3);
		for (int j = 0; j < 2; j++) begin
			{holdoff_function_enable, in_sx_entry, aux_sleep_out_n} <= j ? 3'h2 : 3'h4;
			tick(6);
			check(holdoff_gpio_level, 1'h0);
			if (j) begin
				in_full_s0 <= 1'h0;
				cs_n <= 1'h0;
				tick(1);
				cs_n <= 1'h1;
				tick(5);
				check(holdoff_gpio_level, 1'h1);
			end
			aux_sleep_out_n <= 1'h1;
			in_full_s0 <= 1'h1;
			tick(4);
			check(resume_allowed, 1'h1);
			tick(60);
		end
		$display("holdoff test done");
		power_button_event <= 1'h1;
		tick(1);
		power_button_event <= 1'h0;
		for (int j = 0; j < 2; j++) begin
			{trip_valid_point, processor_power_good, platform_reset_n} <= j ? 3'h2 : 3'h5;
			thermal_trip_n <= 1'h0;
			tick(10);
			check({power_button_status, sleep_s5_out_n}, 2'h3);
			thermal_trip_n <= 1'h1;
			tick(4);
		end
		platform_reset_n <= 1'h1;
		tick(4);
		for (int j = 1; j < 3; j++) begin
			thermal_trip_n <= 1'h0;
			tick(j);
			thermal_trip_n <= 1'h1;
			tick(8);
			check({sleep_s3_out_n, sleep_s4_out_n, sleep_s5_out_n}, 3'h7);
		end
		thermal_trip_n <= 1'h0;
		wait_for(sleep_s5_out_n, 1'h0, 200);
		check(n <= TRIP_LATENCY_CYC, 1'h1);
		check({sleep_s3_out_n, sleep_s4_out_n, thermal_trip_status}, 3'h1);
		check(power_button_status, 1'h0);
		$display("thermal trip test done");
		check(exp_q.size(), 16'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
